/* rtl/swfpe_engine.sv */
// Flag level protocol engine of the single-wire authentication slave.
`timescale 1ns/10ps
`default_nettype none
module swfpe_engine
	import swfpe_pkg::*;
#(
	parameter int         PARSE_CYCLES = swfpe_pkg::PARSE_CYC,
	parameter int         TURN_CYCLES  = swfpe_pkg::TURN_CYC,
	parameter int         WDOG_CYCLES  = swfpe_pkg::WDOG_CYC,
	parameter int         MAC_CYCLES   = swfpe_pkg::EXEC_MAC_CYC,
	parameter int         READ_CYCLES  = swfpe_pkg::EXEC_READ_CYC,
	parameter int         FUSE_CYCLES  = swfpe_pkg::EXEC_FUSE_CYC,
	parameter int         SEC_CYCLES   = swfpe_pkg::EXEC_SEC_CYC,
	parameter int         PERS_CYCLES  = swfpe_pkg::EXEC_PERS_CYC,
	parameter logic [7:0] OP_MAC       = 8'h01,
	parameter logic [7:0] OP_READ      = 8'h02,
	parameter logic [7:0] OP_FUSE      = 8'h03,
	parameter logic [7:0] OP_SECURE    = 8'h04,
	parameter logic [7:0] OP_PERSON    = 8'h05,
	parameter logic [7:0] OP_PAUSE     = 8'h06
) (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Received bytes from the bit decoder.
	input  wire logic       wake_det,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	output logic            rx_enable,
	// Bytes towards the bit encoder.
	output logic            tx_valid,
	input  wire logic       tx_ready,
	output logic [7:0]      tx_data,
	// Command bytes and control towards the executor.
	output logic            cmd_byte_valid,
	output logic [7:0]      cmd_byte,
	output logic [5:0]      cmd_byte_idx,
	output logic            exec_start,
	output logic [7:0]      exec_opcode,
	input  wire logic       exec_done,
	input  wire logic       exec_ok,
	input  wire logic [5:0] resp_len,
	output logic [5:0]      resp_addr,
	input  wire logic [7:0] resp_byte,
	// Fuse address and status.
	input  wire logic [3:0] fuse_addr,
	output logic            sleep_mode,
	output logic            busy,
	output logic            paused
);
	import swfpe_pkg::*;

	typedef struct packed {
		swfpe_state_t  st;
		swfpe_result_t res;
		logic [31:0]   cnt;
		logic [31:0]   wdog;
		logic [15:0]   crc;
		logic [7:0]    crc_lo;
		logic [5:0]    idx;
		logic [5:0]    blk_len;
		logic [7:0]    opcode;
		logic [7:0]    param1;
		logic          parse_ok;
		logic [5:0]    pay_len;
		logic [5:0]    out_len;
		logic          cmd_v;
		logic [7:0]    cmd_b;
		logic [5:0]    cmd_i;
		logic          start;
	} swfpe_st_t;

	swfpe_st_t   s_q;
	swfpe_st_t   s_d;
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic [7:0]  send_byte;
	logic        flush;
	logic [31:0] exec_limit;
	logic [7:0]  code_byte;
	logic [5:0]  resp_len_q;
	logic [5:0]  resp_len_d;

	// One byte of CRC-16, bits taken least significant first.
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
	                                         input logic [7:0] b);
		logic [15:0] r;
		logic        fb;
		r  = c;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			fb = b[i] ^ r[15];
			r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	// Longest allowed execution for the latched opcode.
	// Unknown opcodes fall back to the memory read budget.
	always_comb begin
		if (s_q.opcode == OP_MAC) begin
			exec_limit = MAC_CYCLES;
		end else if (s_q.opcode == OP_READ) begin
			exec_limit = READ_CYCLES;
		end else if (s_q.opcode == OP_FUSE) begin
			exec_limit = FUSE_CYCLES;
		end else if (s_q.opcode == OP_SECURE) begin
			exec_limit = SEC_CYCLES;
		end else if (s_q.opcode == OP_PERSON) begin
			exec_limit = PERS_CYCLES;
		end else begin
			exec_limit = READ_CYCLES;
		end
	end

	// Status code matching the stored result.
	// Success never uses this code; the executor's bytes go out instead.
	always_comb begin
		case (s_q.res)
			RES_WAKE: code_byte = CODE_WAKE;
			RES_EXER: code_byte = CODE_EXEC_ERR;
			RES_COMM: code_byte = CODE_COMM_ERR;
			default:  code_byte = CODE_WAKE;
		endcase
	end

	// Byte of the outgoing block: count, payload, then CRC low and high.
	always_comb begin
		if (s_q.idx == 6'h00) begin
			send_byte = {2'b00, s_q.out_len};
		end else if (s_q.idx <= s_q.pay_len) begin
			send_byte = (s_q.res == RES_OK) ? resp_byte : code_byte;
		end else if (s_q.idx == s_q.pay_len + 6'h01) begin
			send_byte = s_q.crc[7:0];
		end else begin
			send_byte = s_q.crc[15:8];
		end
	end

	assign fifo_in_valid = (s_q.st == ST_SEND);
	assign resp_addr     = s_q.idx - 6'h01;

	// Main sequencer.
	always_comb begin
		s_d       = s_q;
		s_d.cmd_v = 1'b0;
		s_d.start = 1'b0;
		flush     = 1'b0;
		case (s_q.st)
			ST_SLEEP: begin
				// Only a wake token leaves low power.
				if (wake_det) begin
					s_d.st   = ST_IDLE;
					s_d.res  = RES_WAKE;
					s_d.wdog = '0;
				end
			end
			ST_IDLE: begin
				// Every byte seen here is a flag.
				if (rx_valid) begin
					if (rx_data == FLAG_COMMAND) begin
						s_d.st  = ST_RXBLK;
						s_d.idx = '0;
						s_d.crc = CRC_INIT;
					end else if (rx_data == FLAG_TRANSMIT) begin
						s_d.st  = ST_TURN;
						s_d.cnt = '0;
						s_d.pay_len = (s_q.res == RES_OK) ? resp_len_q : 6'h01;
					end else if (rx_data == FLAG_SLEEP) begin
						// Flags are only accepted here.
						s_d.st = ST_SLEEP;
						flush  = 1'b1;
					end
					// Reserved flag values fall through untouched.
				end
			end
			ST_RXBLK: begin
				if (rx_valid) begin
					s_d.idx = s_q.idx + 6'h01;
					if (s_q.idx == 6'h00) begin
						s_d.crc     = crc_byte(s_q.crc, rx_data);
						s_d.blk_len = rx_data[5:0];
						// A count out of range cannot be framed; give up at once.
						if (rx_data < BLK_MIN || rx_data > BLK_MAX) begin
							s_d.st       = ST_PARSE;
							s_d.parse_ok = 1'b0;
							s_d.cnt      = '0;
						end
					end else if (s_q.idx < s_q.blk_len - 6'h02) begin
						s_d.crc   = crc_byte(s_q.crc, rx_data);
						s_d.cmd_v = 1'b1;
						s_d.cmd_b = rx_data;
						s_d.cmd_i = s_q.idx;
						if (s_q.idx == 6'h01) begin
							s_d.opcode = rx_data;
						end
						if (s_q.idx == 6'h02) begin
							s_d.param1 = rx_data;
						end
					end else if (s_q.idx == s_q.blk_len - 6'h02) begin
						s_d.crc_lo = rx_data;
					end else begin
						s_d.st       = ST_PARSE;
						s_d.cnt      = '0;
						s_d.parse_ok = ({rx_data, s_q.crc_lo} == s_q.crc);
					end
				end
			end
			ST_PARSE: begin
				// Wire is ignored until the parse delay has run out.
				s_d.cnt = s_q.cnt + 32'h1;
				if (s_q.cnt >= PARSE_CYCLES - 1) begin
					s_d.cnt = '0;
					if (!s_q.parse_ok) begin
						s_d.st  = ST_IDLE;
						s_d.res = RES_COMM;
					end else if (s_q.opcode == OP_PAUSE) begin
						// Address field sits in the low nibble of the first parameter.
						if (s_q.param1[3:0] == fuse_addr) begin
							s_d.st = ST_PAUSE;
						end else begin
							s_d.st = ST_IDLE;
						end
					end else begin
						s_d.st    = ST_EXEC;
						s_d.start = 1'b1;
					end
				end
			end
			ST_EXEC: begin
				// Silent until the executor reports or its time is spent.
				s_d.cnt = s_q.cnt + 32'h1;
				if (exec_done) begin
					s_d.st  = ST_IDLE;
					s_d.res = exec_ok ? RES_OK : RES_EXER;
				end else if (s_q.cnt >= exec_limit - 1) begin
					s_d.st  = ST_IDLE;
					s_d.res = RES_EXER;
				end
			end
			ST_TURN: begin
				// Hold off the first edge by the turnaround delay.
				// Counted from the flag byte; bit-layer latency adds to it.
				s_d.cnt = s_q.cnt + 32'h1;
				if (s_q.cnt >= TURN_CYCLES - 1) begin
					s_d.st      = ST_SEND;
					s_d.idx     = '0;
					s_d.crc     = CRC_INIT;
					s_d.out_len = s_q.pay_len + BLK_OVERHEAD;
				end
			end
			ST_SEND: begin
				// One byte per accepted push; CRC follows count and payload.
				if (fifo_in_ready) begin
					s_d.idx = s_q.idx + 6'h01;
					if (s_q.idx <= s_q.pay_len) begin
						s_d.crc = crc_byte(s_q.crc, send_byte);
					end
					// The CRC high byte at index out_len-1 is the last push.
					if (s_q.idx == s_q.out_len - 6'h01) begin
						s_d.st = ST_IDLE;
					end
				end
			end
			ST_PAUSE: begin
				// Full power, wire ignored; only the watchdog ends it.
				s_d.st = ST_PAUSE;
			end
			default: begin
				s_d.st = ST_SLEEP;
			end
		endcase
		// Watchdog runs from wake and overrides everything.
		// Only sleep restarts it, so even a hung executor is bounded.
		if (s_q.st != ST_SLEEP) begin
			s_d.wdog = s_q.wdog + 32'h1;
			if (s_q.wdog >= WDOG_CYCLES - 1) begin
				s_d.st   = ST_SLEEP;
				s_d.wdog = '0;
				flush    = 1'b1;
			end
		end
		// Entering sleep clears the result, index, delay counter, parse flag, opcode and first parameter.
		if (s_d.st == ST_SLEEP && s_q.st != ST_SLEEP) begin
			s_d.res      = RES_WAKE;
			s_d.idx      = '0;
			s_d.cnt      = '0;
			s_d.parse_ok = 1'b0;
			s_d.opcode   = '0;
			s_d.param1   = '0;
		end
	end

	// Response length is captured when the executor finishes.
	// It outlives the send so that a repeated transmit flag re-reads it.
	always_comb begin
		resp_len_d = resp_len_q;
		if (s_q.st == ST_EXEC && exec_done) begin
			resp_len_d = resp_len;
		end
	end

	// State registers; the engine wakes in sleep.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q        <= '{st: ST_SLEEP, res: RES_WAKE, default: '0};
			resp_len_q <= '0;
		end else begin
			s_q        <= s_d;
			resp_len_q <= resp_len_d;
		end
	end

	// Status and executor outputs come from the registered state.
	// Busy spans parse and execution, two of the windows in which the wire is deaf.
	assign rx_enable      = (s_q.st == ST_IDLE) || (s_q.st == ST_RXBLK);
	assign sleep_mode     = (s_q.st == ST_SLEEP);
	assign busy           = (s_q.st == ST_PARSE) || (s_q.st == ST_EXEC);
	assign paused         = (s_q.st == ST_PAUSE);
	assign cmd_byte_valid = s_q.cmd_v;
	assign cmd_byte       = s_q.cmd_b;
	assign cmd_byte_idx   = s_q.cmd_i;
	assign exec_start     = s_q.start;
	assign exec_opcode    = s_q.opcode;

	// Four words of buffering decouple the engine from the bit encoder.
	// A stalled encoder only holds the engine in SEND; no byte is lost.
	swfpe_fifo #(
		.W(FIFO_WIDTH),
		.D(FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.flush     (flush),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (send_byte),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);
endmodule // swfpe_engine
`default_nettype wire

/* rtl/swfpe_pkg.sv */
// Constants and types shared by the single-wire flag protocol engine.
// How it works
// - Command flag starts command block reception; block may follow without gap.
// - Transmit flag waits turnaround, then sends the response of the last block.
// - Sleep flag enters low power until the next wake token.
// - Any other flag value is ignored without any action.
// - While parsing or executing, the engine is busy and ignores the wire.
// - Checksum and parse finish within the parse delay; errors show afterwards.
// - Keyed digest finishes within 30 ms, memory read within 3 ms.
// - Fuse program 700 us, secure lock 36 ms, personalization key 13 ms.
// - Transmit before any command after wake returns status 0x11.
// - After success, output bytes are returned, again on every transmit flag.
// - Command received but not executable returns status 0x0F.
// - Checksum or framing error returns 0xFF and nothing is executed.
// - Only whole blocks go out; status is count, code, two checksum bytes.
// - After parse, errors answer at once; otherwise execute, silent till done.
// - Sleep flag resets engine and buffer; accepted whenever flags are accepted.
// - Pause ignores the wire at full power and ends only by watchdog sleep.
// - Pause address field compared with fuses 84-87; match pauses, else monitor.
// - Watchdog started at wake forces sleep, whatever is in progress.
// - First response edge comes 28 to 95 us after the transmit flag ends.
// - Checksum is CRC-16, polynomial 0x8005, zero start, low byte first.
// - Every byte, flags included, moves least significant bit first.
package swfpe_pkg;

	// Flag values.
	localparam logic [7:0] FLAG_COMMAND  = 8'h77;
	localparam logic [7:0] FLAG_TRANSMIT = 8'h88;
	localparam logic [7:0] FLAG_SLEEP    = 8'hCC;

	// Status codes returned in a four-byte block.
	localparam logic [7:0] CODE_WAKE     = 8'h11;
	localparam logic [7:0] CODE_EXEC_ERR = 8'h0F;
	localparam logic [7:0] CODE_COMM_ERR = 8'hFF;

	// Block framing.
	localparam logic [7:0]  BLK_MIN      = 8'h04;
	localparam logic [7:0]  BLK_MAX      = 8'h27;
	localparam logic [5:0]  BLK_OVERHEAD = 6'h03;
	localparam logic [15:0] CRC_POLY     = 16'h8005;
	localparam logic [15:0] CRC_INIT     = 16'h0000;

	// Timing in printed units and derived cycle counts at 200 MHz.
	localparam int CLK_MHZ      = 200;
	localparam int PARSE_US     = 100;
	localparam int TURN_US      = 60;
	localparam int WDOG_MS      = 4000;
	localparam int EXEC_MAC_MS  = 30;
	localparam int EXEC_READ_MS = 3;
	localparam int EXEC_FUSE_US = 700;
	localparam int EXEC_SEC_MS  = 36;
	localparam int EXEC_PERS_MS = 13;
	localparam int PARSE_CYC     = PARSE_US * CLK_MHZ;
	localparam int TURN_CYC      = TURN_US * CLK_MHZ;
	localparam int WDOG_CYC      = WDOG_MS * 1000 * CLK_MHZ;
	localparam int EXEC_MAC_CYC  = EXEC_MAC_MS * 1000 * CLK_MHZ;
	localparam int EXEC_READ_CYC = EXEC_READ_MS * 1000 * CLK_MHZ;
	localparam int EXEC_FUSE_CYC = EXEC_FUSE_US * CLK_MHZ;
	localparam int EXEC_SEC_CYC  = EXEC_SEC_MS * 1000 * CLK_MHZ;
	localparam int EXEC_PERS_CYC = EXEC_PERS_MS * 1000 * CLK_MHZ;

	// Buffer shape.
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 8;

	// Engine states, one-hot.
	typedef enum logic [7:0] {
		ST_SLEEP = 8'b0000_0001,
		ST_IDLE  = 8'b0000_0010,
		ST_RXBLK = 8'b0000_0100,
		ST_PARSE = 8'b0000_1000,
		ST_EXEC  = 8'b0001_0000,
		ST_TURN  = 8'b0010_0000,
		ST_SEND  = 8'b0100_0000,
		ST_PAUSE = 8'b1000_0000
	} swfpe_state_t;

	// What the next transmit flag answers with.
	typedef enum logic [1:0] {
		RES_WAKE = 2'h0,
		RES_OK   = 2'h1,
		RES_EXER = 2'h2,
		RES_COMM = 2'h3
	} swfpe_result_t;

endpackage

/* rtl/swfpe_fifo.sv */
// Small synchronous FIFO between the engine and the bit encoder.
`timescale 1ns/10ps
`default_nettype none
module swfpe_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset.
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW-1:0] LAST = AW'(D - 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} swfpe_fifo_st_t;

	swfpe_fifo_st_t s_q;
	swfpe_fifo_st_t s_d;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (s_q.cnt != (AW+1)'(D));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap by compare so any depth works, not only powers of two.
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == LAST) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == LAST) ? '0 : s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		if (flush) begin
			s_d.wp  = '0;
			s_d.rp  = '0;
			s_d.cnt = '0;
		end
	end

	// State register.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // swfpe_fifo
`default_nettype wire

/* tb/swfpe_engine_props.sv */
// Concurrent checks on the ports of the flag protocol engine.
`timescale 1ns/10ps
`default_nettype none
module swfpe_engine_props #(
	parameter int PARSE_CYCLES = 20,
	parameter int TURN_CYCLES  = 10,
	parameter int WDOG_CYCLES  = 4000
) (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Byte input side.
	input  wire logic       wake_det,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_enable,
	// Byte output side.
	input  wire logic       tx_valid,
	input  wire logic       tx_ready,
	input  wire logic [7:0] tx_data,
	// Engine status.
	input  wire logic       exec_start,
	input  wire logic       sleep_mode,
	input  wire logic       busy,
	input  wire logic       paused
);
	localparam int T_LO = TURN_CYCLES;
	localparam int T_HI = TURN_CYCLES + 4;
	logic blk_q;
	int   bcnt_q;
	int   wcnt_q;
	logic idle;

	// Block reception cannot be seen at the ports, so the flag is tracked here.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_q  <= 1'b0;
			bcnt_q <= 0;
			wcnt_q <= 0;
		end else begin
			if (!rx_enable)
				blk_q <= 1'b0;
			else if (idle && rx_valid && rx_data == 8'h77)
				blk_q <= 1'b1;
			bcnt_q <= busy ? bcnt_q + 1 : 0;
			wcnt_q <= sleep_mode ? 0 : wcnt_q + 1;
		end
	end
	assign idle = rx_enable && !blk_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_busy_deaf: assert property (busy |-> !rx_enable)
		else $error("engine listens while busy");
	a_pause_deaf: assert property (paused |-> !rx_enable && !busy)
		else $error("paused engine is not idle on the wire");
	a_sleep_flag: assert property (idle && rx_valid && rx_data == 8'hCC
		|=> sleep_mode && !tx_valid) else $error("sleep flag not obeyed");
	a_reserved_flag: assert property (idle && rx_valid &&
		!(rx_data inside {8'h77, 8'h88, 8'hCC}) |=> idle && !busy)
		else $error("reserved flag changed state");
	a_parse_delay: assert property (exec_start |->
		bcnt_q >= PARSE_CYCLES - 1 && bcnt_q <= PARSE_CYCLES + 2)
		else $error("execution start off the parse delay");
	a_start_pulse: assert property (exec_start |-> busy ##1 !exec_start)
		else $error("start is not a busy one-cycle pulse");
	a_turn_around: assert property (idle && rx_valid && rx_data == 8'h88
		|-> ##[T_LO:T_HI] $rose(tx_valid)) else $error("turnaround out of range");
	a_tx_hold: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data)) else $error("output byte withdrawn");
	a_watch_dog: assert property (wcnt_q <= WDOG_CYCLES + 2)
		else $error("watchdog did not force sleep");
	a_wake_up: assert property (sleep_mode && wake_det |=> !sleep_mode)
		else $error("wake token not honoured");

	// Main scenarios that the bench is meant to reach.
	c_exec: cover property (exec_start);
	c_pause: cover property (paused);
	c_stall: cover property (tx_valid && !tx_ready);
	c_wake: cover property ($fell(sleep_mode));
endmodule // swfpe_engine_props
`default_nettype wire

/* tb/swfpe_exec_model.sv */
// Executor and stalling bit encoder that face the engine.
`timescale 1ns/10ps
`default_nettype none
module swfpe_exec_model #(
	parameter int DLY = 30
) (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Behaviour selection from the bench.
	input  wire logic       ok_mode,
	input  wire logic       late,
	input  wire logic       stall,
	// Executor side.
	input  wire logic       exec_start,
	output logic            exec_done,
	output logic            exec_ok,
	output logic [5:0]      resp_len,
	input  wire logic [5:0] resp_addr,
	output logic [7:0]      resp_byte,
	// Encoder side.
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] cnt_q;
	logic [7:0] lfsr_q;

	// Count the execution time and stir a stall pattern for the encoder.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			lfsr_q <= 8'h5A;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4]
				^ lfsr_q[3]};
			if (exec_start && !late)
				cnt_q <= 8'(DLY);
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 8'h01;
		end
	end

	// A late executor never answers, so only the engine's limit ends it.
	assign exec_done = cnt_q == 8'h01;
	assign exec_ok   = ok_mode;
	assign resp_len  = 6'h03;
	assign resp_byte = {2'b10, resp_addr} ^ 8'hA5;
	assign tx_ready  = !stall || (lfsr_q[0] && tx_valid);
endmodule // swfpe_exec_model
`default_nettype wire

/* tb/swfpe_engine_test.sv */
// Self-checking bench for the flag protocol engine.
`timescale 1ns/10ps
`default_nettype none
module swfpe_engine_test;
	import swfpe_pkg::*;
	logic       core_clk, rst_n, wake_det, rx_valid, rx_enable;
	logic [7:0] rx_data, tx_data, f;
	logic       tx_valid, tx_ready, exec_start, exec_done, exec_ok;
	logic [5:0] resp_len, resp_addr;
	logic [7:0] resp_byte;
	logic [3:0] fuse_addr;
	logic       sleep_mode, busy, paused, ok_mode, late, stall;
	logic [7:0] okq[$];
	int         n_errors, n_compared, cyc;
	logic       cbv;
	logic [7:0] cbyte, opc, dat_q, dat_seen;
	logic [5:0] cbidx;

	// Only the delays the run depends on are shortened; the rest keep defaults.
	swfpe_engine #(.PARSE_CYCLES(20), .TURN_CYCLES(10), .WDOG_CYCLES(4000),
		.FUSE_CYCLES(50)) u_swfpe_engine (
		.core_clk(core_clk), .rst_n(rst_n), .wake_det(wake_det),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_enable(rx_enable),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.cmd_byte_valid(cbv), .cmd_byte(cbyte), .cmd_byte_idx(cbidx),
		.exec_start(exec_start), .exec_opcode(opc), .exec_done(exec_done),
		.exec_ok(exec_ok), .resp_len(resp_len), .resp_addr(resp_addr),
		.resp_byte(resp_byte), .fuse_addr(fuse_addr),
		.sleep_mode(sleep_mode), .busy(busy), .paused(paused));
	swfpe_exec_model u_swfpe_exec_model (.core_clk(core_clk),
		.rst_n(rst_n), .ok_mode(ok_mode), .late(late), .stall(stall),
		.exec_start(exec_start), .exec_done(exec_done),
		.exec_ok(exec_ok), .resp_len(resp_len), .resp_addr(resp_addr),
		.resp_byte(resp_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

	// Free-running clock and a cut-off for a hung engine.
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	// Keep the last data byte the engine forwarded to the executor.
	always @(negedge core_clk)
		if (cbv === 1'b1 && cbidx === 6'h03)
			dat_seen <= cbyte;

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Checksum of the count and packet, bits taken low first.
	function automatic logic [15:0] crc(logic [7:0] q[$]);
		logic [15:0] c;
		c = '0;
		foreach (q[i])
			for (int k = 0; k < 8; k++)
				c = {c[14:0], 1'b0} ^ ((q[i][k] ^ c[15]) ? 16'h8005 : 16'h0);
		return c;
	endfunction

	// One decoded byte, a single-cycle pulse entered at the falling edge.
	task automatic put(logic [7:0] b);
		rx_data  <= b;
		rx_valid <= 1'b1;
		@(negedge core_clk) rx_valid <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic wake();
		wake_det <= 1'b1;
		@(negedge core_clk) wake_det <= 1'b0;
		@(negedge core_clk);
	endtask

	// A six-byte command block; a flipped checksum bit models line noise.
	task automatic cmd(logic [7:0] op, logic [7:0] p1, logic bad);
		logic [7:0]  q[$];
		logic [15:0] c;
		q = {8'h06, op, p1, 8'($urandom)};
		c = crc(q) ^ {15'h0, bad};
		dat_q = q[3];
		put(8'h77);
		foreach (q[i]) put(q[i]);
		put(c[7:0]);
		put(c[15:8]);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		chk("busy", {7'h0, busy}, 8'h00);
	endtask

	// Ask for the answer and compare the whole block, then silence.
	task automatic rsp(logic [7:0] pay[$]);
		logic [7:0]  q[$];
		logic [15:0] c;
		int          n;
		q = {8'(pay.size() + 3), pay};
		c = crc(q);
		q = {q, c[7:0], c[15:8]};
		put(FLAG_TRANSMIT);
		foreach (q[i]) begin
			n = 0;
			do begin
				@(negedge core_clk);
				n++;
			end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 200);
			chk("tx_byte", tx_data, q[i]);
		end
		repeat (4) @(negedge core_clk);
		chk("tx_idle", {7'h0, tx_valid}, 8'h00);
	endtask

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		wake_det = 1'b0;
		rx_valid = 1'b0;
		rx_data = '0;
		ok_mode = 1'b1;
		late = 1'b0;
		stall = 1'b0;
		fuse_addr = '0;
		void'($urandom(30));
		for (int i = 0; i < 3; i++) okq.push_back(8'h80 ^ 8'(i) ^ 8'hA5);
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		chk("sleep_rst", {7'h0, sleep_mode}, 8'h01);
		wake();
		rsp({CODE_WAKE});
		repeat (4) begin
			do f = 8'($urandom); while (f inside {8'h77, 8'h88, 8'hCC});
			put(f);
		end
		rsp({CODE_WAKE});
		stall = 1'b1;
		for (int op = 1; op <= 5; op++) begin
			cmd(8'(op), 8'($urandom), 1'b0);
			put(FLAG_TRANSMIT);
			settle();
			chk("opcode", opc, 8'(op));
			chk("cmd_byte", dat_seen, dat_q);
			rsp(okq);
		end
		rsp(okq);
		cmd(8'h02, 8'($urandom), 1'b1);
		settle();
		rsp({CODE_COMM_ERR});
		ok_mode = 1'b0;
		cmd(8'h02, 8'($urandom), 1'b0);
		settle();
		rsp({CODE_EXEC_ERR});
		ok_mode = 1'b1;
		late = 1'b1;
		cmd(8'h03, 8'($urandom), 1'b0);
		settle();
		rsp({CODE_EXEC_ERR});
		late = 1'b0;
		put(FLAG_SLEEP);
		chk("sleep", {7'h0, sleep_mode}, 8'h01);
		put(FLAG_TRANSMIT);
		wake();
		rsp({CODE_WAKE});
		fuse_addr = 4'($urandom);
		cmd(8'h06, {4'h0, ~fuse_addr}, 1'b0);
		settle();
		chk("paused", {7'h0, paused}, 8'h00);
		rsp({CODE_WAKE});
		cmd(8'h06, {4'h0, fuse_addr}, 1'b0);
		settle();
		chk("paused", {7'h0, paused}, 8'h01);
		put(FLAG_TRANSMIT);
		for (int n = 0; n < 4500 && sleep_mode !== 1'b1; n++)
			@(negedge core_clk);
		chk("wdog", {6'h0, sleep_mode, tx_valid}, 8'h02);
		conclude();
	end
endmodule // swfpe_engine_test

bind swfpe_engine swfpe_engine_props #(.PARSE_CYCLES(PARSE_CYCLES),
	.TURN_CYCLES(TURN_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .wake_det(wake_det),
	.rx_valid(rx_valid), .rx_data(rx_data), .rx_enable(rx_enable),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
	.exec_start(exec_start), .sleep_mode(sleep_mode), .busy(busy),
	.paused(paused));
`default_nettype wire
